// File: rtl/uef_pkg.sv
package uef_pkg;
  // register offsets
  localparam logic [7:0] ADDR_NOTIF_MASK = 8'h07;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h08;
  localparam logic [7:0] ADDR_NOTIF      = 8'h0A;
  localparam logic [7:0] ADDR_FAULT      = 8'h0B;

  // notification flag positions
  localparam int NB_UNCONFIG      = 7;
  localparam int NB_STATE_CHANGE  = 5;
  localparam int NB_CONN_ATTACH   = 4;
  localparam int NB_LEGACY_ATTACH = 3;
  localparam int NB_CONN_EDGE     = 2;
  localparam int NB_LEGACY_EDGE   = 1;
  localparam int NB_ADC_DONE      = 0;
  localparam int NOTIF_FLAGS      = 6;

  // fault flag positions
  localparam int FB_PRE_OV        = 6;
  localparam int FB_LIMIT_UV      = 5;
  localparam int FB_CURRENT_LIMIT = 4;
  localparam int FB_OVERVOLT      = 3;
  localparam int FB_UNDERVOLT     = 2;
  localparam int FB_SHORT_GND     = 1;
  localparam int FB_THERMAL       = 0;
  localparam int FAULT_FLAGS      = 7;

  // auto-clear control sits in the notification mask register
  localparam int MB_AUTO_CLEAR    = 7;

  // nominal die shutdown trip, degrees C, set by the analog detector
  localparam int THERMAL_TRIP_C   = 165;

  // reset values
  localparam logic [7:0] RST_NOTIF_MASK = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;
  localparam logic [7:0] RST_READ_DATA  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
endpackage

// File: rtl/uef_flag_bank.sv
`timescale 1ns/1ps
module uef_flag_bank #(
  parameter int WIDTH = 7
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] setIn,
  input  wire logic [WIDTH-1:0] condIn,
  input  wire logic [WIDTH-1:0] holdEn,
  input  wire logic [WIDTH-1:0] autoEn,
  input  wire logic             readClear,
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;
  wire  [WIDTH-1:0] keepOnRead;
  wire  [WIDTH-1:0] autoDrop;

  if (WIDTH < 1 || WIDTH > 8) begin : g_chk
    $error("uef_flag_bank: WIDTH must be 1 to 8");
  end

  // persistent conditions survive a read
  assign keepOnRead = holdEn & condIn;
  assign autoDrop   = autoEn & ~condIn;
  // set wins over any clear in the same cycle
  assign flags_nxt  = setIn | (flags_r & ~({WIDTH{readClear}} & ~keepOnRead) & ~autoDrop);
  assign flags      = flags_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule

// File: rtl/uef_port_flags.sv
`timescale 1ns/1ps
// Summary of operation
// - notification register at 0xA, masked onto interrupt
// - bit 7 high until configuration done
// - state-change flag sticky until read, no auto-clear
// - bit 4 shows sink attach as source
// - bit 3 shows legacy charging attach
// - bit 2 on connector attach edges only
// - bit 1 on legacy attach edges only
// - bit 0 on ADC done, read clears
// - fault register at 0xB, reset zero, masked
// - read clears fault only when condition gone
// - bit 6 pre-overvoltage, detection on, unattached
// - bit 5 suppressed when trip mode is 1
// - bit 4 suppressed when trip mode is 0
// - bits 3/2 sense-pin over/undervoltage
// - bit 1 sense-pin short to ground
// - bit 0 thermal shutdown detector
// - auto-clear drops fault and attach-level flags once condition gone
// - mask registers, reset 0, enable per flag except unconfigured bit 7
module uef_port_flags #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrEn,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  input  wire logic              configDone,
  input  wire logic              connStateChange,
  input  wire logic              connAttachStatus,
  input  wire logic              connSourceState,
  input  wire logic              legacyChargeAttach,
  input  wire logic              adcDone,
  input  wire logic              connDetectEnable,
  input  wire logic              busMonitorOv,
  input  wire logic              busLimitUndervoltRaw,
  input  wire logic              busCurrentLimitRaw,
  input  wire logic              senseOvervoltage,
  input  wire logic              senseUndervoltage,
  input  wire logic              senseShortGround,
  input  wire logic              thermalShutdown,
  input  wire logic              limitTripMode,
  output logic                   irqOut
);
  localparam int NF = uef_pkg::NOTIF_FLAGS;
  localparam int FF = uef_pkg::FAULT_FLAGS;

  if (ADDR_W < 4 || ADDR_W > 8) begin : g_chk
    $error("uef_port_flags: ADDR_W must be 4 to 8");
  end

  logic [7:0]    notifMask_r;
  logic [7:0]    faultMask_r;
  logic [7:0]    regRdData_r;
  logic          connAttachPrev_r;
  logic          legacyAttachPrev_r;
  logic [NF-1:0] notifFlags;
  logic [FF-1:0] faultFlags;

  wire [7:0] addr8 = 8'(regAddr);
  wire       selNotifMask = (addr8 == uef_pkg::ADDR_NOTIF_MASK);
  wire       selFaultMask = (addr8 == uef_pkg::ADDR_FAULT_MASK);
  wire       selNotif     = (addr8 == uef_pkg::ADDR_NOTIF);
  wire       selFault     = (addr8 == uef_pkg::ADDR_FAULT);
  wire       rdNotif      = regRdEn & selNotif;
  wire       rdFault      = regRdEn & selFault;
  wire       autoClear    = notifMask_r[uef_pkg::MB_AUTO_CLEAR];

  // sink attach seen while attached as source
  wire connAttached = connAttachStatus & connSourceState;
  wire connEdge     = connAttachStatus ^ connAttachPrev_r;
  wire legacyEdge   = legacyChargeAttach ^ legacyAttachPrev_r;

  // notification set terms, bit order 5..0
  // adc done is an event bit
  wire [NF-1:0] notifSet = {connStateChange, connAttached, legacyChargeAttach,
                            connEdge, legacyEdge, adcDone};
  // legacy attach level held while present
  wire [NF-1:0] notifCond = {1'b0, connAttached, legacyChargeAttach, 3'b000};
  wire [NF-1:0] notifHold = 6'h18;
  wire [NF-1:0] notifAuto = {1'b0, autoClear, autoClear, 3'b000};

  // pre-overvoltage only when detecting and unattached
  wire preOv     = busMonitorOv & connDetectEnable & ~connAttachStatus;
  // limit-undervoltage masked in trip mode 1
  wire limitUv   = busLimitUndervoltRaw & ~limitTripMode;
  // current limit masked in trip mode 0
  wire curLimit  = busCurrentLimitRaw & limitTripMode;
  wire [FF-1:0] faultCond = {preOv, limitUv, curLimit, senseOvervoltage,
                             senseUndervoltage, senseShortGround, thermalShutdown};

  uef_flag_bank #(
    .WIDTH (NF)
  ) u_notif (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .setIn     (notifSet),
    .condIn    (notifCond),
    .holdEn    (notifHold),
    .autoEn    (notifAuto),
    .readClear (rdNotif),
    .flags     (notifFlags)
  );

  // faults hold while present, auto-clear optional
  uef_flag_bank #(
    .WIDTH (FF)
  ) u_fault (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .setIn     (faultCond),
    .condIn    (faultCond),
    .holdEn    ({FF{1'b1}}),
    .autoEn    ({FF{autoClear}}),
    .readClear (rdFault),
    .flags     (faultFlags)
  );

  // unconfigured indicator follows the configuration bit
  wire [7:0] notifView = {~configDone, 1'b0, notifFlags};
  wire [7:0] faultView = {1'b0, faultFlags};
  wire [7:0] rdValue = selNotif     ? notifView :
                       selFault     ? faultView :
                       selNotifMask ? notifMask_r :
                       selFaultMask ? faultMask_r :
                       uef_pkg::READ_UNMAPPED;

  // mask registers, reserved bits not stored
  wire [7:0] notifMaskNxt = {regWrData[7], 1'b0, regWrData[5:0]};
  wire [7:0] faultMaskNxt = {1'b0, regWrData[6:0]};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      notifMask_r <= uef_pkg::RST_NOTIF_MASK;
      faultMask_r <= uef_pkg::RST_FAULT_MASK;
    end else if (regWrEn) begin
      if (selNotifMask) begin
        notifMask_r <= notifMaskNxt;
      end
      if (selFaultMask) begin
        faultMask_r <= faultMaskNxt;
      end
    end
  end

  // edge trackers reset unattached, so an attach present at release counts once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      connAttachPrev_r   <= 1'b0;
      legacyAttachPrev_r <= 1'b0;
    end else begin
      connAttachPrev_r   <= connAttachStatus;
      legacyAttachPrev_r <= legacyChargeAttach;
    end
  end

  // read data holds until the next read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_r <= uef_pkg::RST_READ_DATA;
    end else if (regRdEn) begin
      regRdData_r <= rdValue;
    end
  end
  assign regRdData = regRdData_r;

  // interrupt from masked flags; unconfigured bit has no enable
  wire irqNotif = |(notifFlags & notifMask_r[NF-1:0]);
  wire irqFault = |(faultFlags & faultMask_r[FF-1:0]);
  assign irqOut = irqNotif | irqFault;

  // assertions
  sequence s_readNotif;
    regRdEn && selNotif;
  endsequence

  sequence s_readFault;
    regRdEn && selFault;
  endsequence

  property p_unconfigRead;
    @(posedge core_clk) disable iff (!rst_n)
    s_readNotif |=> (regRdData[7] == !$past(configDone));
  endproperty
  a_unconfigRead: assert property (p_unconfigRead) else $error("unconfigured bit wrong");

  property p_stateHold;
    @(posedge core_clk) disable iff (!rst_n)
    (notifFlags[uef_pkg::NB_STATE_CHANGE] && !rdNotif) |=> notifFlags[uef_pkg::NB_STATE_CHANGE];
  endproperty
  a_stateHold: assert property (p_stateHold) else $error("state change flag lost");

  property p_connEdge;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(connAttachStatus) |=> notifFlags[uef_pkg::NB_CONN_EDGE];
  endproperty
  a_connEdge: assert property (p_connEdge) else $error("attach edge not flagged");

  property p_legacyEdgeOnly;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(notifFlags[uef_pkg::NB_LEGACY_EDGE]) |-> $past(legacyEdge);
  endproperty
  a_legacyEdgeOnly: assert property (p_legacyEdgeOnly) else $error("stray legacy edge");

  property p_adcClear;
    @(posedge core_clk) disable iff (!rst_n)
    (s_readNotif and !adcDone) |=> !notifFlags[uef_pkg::NB_ADC_DONE];
  endproperty
  a_adcClear: assert property (p_adcClear) else $error("adc flag not cleared by read");

  property p_faultPersist;
    @(posedge core_clk) disable iff (!rst_n)
    (s_readFault and thermalShutdown) |=> faultFlags[uef_pkg::FB_THERMAL];
  endproperty
  a_faultPersist: assert property (p_faultPersist) else $error("persistent fault cleared");

  property p_faultResolved;
    @(posedge core_clk) disable iff (!rst_n)
    (s_readFault and !thermalShutdown) |=> !faultFlags[uef_pkg::FB_THERMAL];
  endproperty
  a_faultResolved: assert property (p_faultResolved) else $error("resolved fault kept");

  property p_preOv;
    @(posedge core_clk) disable iff (!rst_n)
    (busMonitorOv && connDetectEnable && !connAttachStatus) |=> faultFlags[uef_pkg::FB_PRE_OV];
  endproperty
  a_preOv: assert property (p_preOv) else $error("pre-overvoltage not flagged");

  property p_limitUvSupp;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(faultFlags[uef_pkg::FB_LIMIT_UV]) |->
      ($past(busLimitUndervoltRaw) && !$past(limitTripMode));
  endproperty
  a_limitUvSupp: assert property (p_limitUvSupp) else $error("limit-uv in mode 1");

  property p_curLimitSupp;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(faultFlags[uef_pkg::FB_CURRENT_LIMIT]) |->
      ($past(busCurrentLimitRaw) && $past(limitTripMode));
  endproperty
  a_curLimitSupp: assert property (p_curLimitSupp) else $error("limit set in mode 0");

  property p_autoClear;
    @(posedge core_clk) disable iff (!rst_n)
    (autoClear && faultFlags[uef_pkg::FB_OVERVOLT] && !senseOvervoltage) |=>
      !faultFlags[uef_pkg::FB_OVERVOLT];
  endproperty
  a_autoClear: assert property (p_autoClear) else $error("auto-clear did not drop flag");

  property p_irqMasked;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(irqOut) |-> (|notifMask_r[NF-1:0]) || (|faultMask_r[FF-1:0]);
  endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("interrupt with all masks clear");

  property p_irqThermal;
    @(posedge core_clk) disable iff (!rst_n)
    (thermalShutdown && faultMask_r[uef_pkg::FB_THERMAL] && !(regWrEn && selFaultMask)) |=>
      irqOut;
  endproperty
  a_irqThermal: assert property (p_irqThermal) else $error("fault gave no irq");

  property p_reservedZero;
    @(posedge core_clk) disable iff (!rst_n)
    (s_readNotif or s_readFault) |=> (regRdData[6] == 1'b0 || $past(selFault)) &&
      (regRdData[7] == 1'b0 || $past(selNotif));
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bit set");

  property p_stateSet;
    @(posedge core_clk) disable iff (!rst_n)
    connStateChange |=> notifFlags[uef_pkg::NB_STATE_CHANGE];
  endproperty
  a_stateSet: assert property (p_stateSet) else $error("state change not flagged");

  property p_srcAttach;
    @(posedge core_clk) disable iff (!rst_n)
    (connAttachStatus && connSourceState) |=> notifFlags[uef_pkg::NB_CONN_ATTACH];
  endproperty
  a_srcAttach: assert property (p_srcAttach) else $error("source attach lost");

  property p_legacySet;
    @(posedge core_clk) disable iff (!rst_n)
    legacyChargeAttach |=> notifFlags[uef_pkg::NB_LEGACY_ATTACH];
  endproperty
  a_legacySet: assert property (p_legacySet) else $error("legacy attach lost");

  property p_senseOv;
    @(posedge core_clk) disable iff (!rst_n)
    senseOvervoltage |=> faultFlags[uef_pkg::FB_OVERVOLT];
  endproperty
  a_senseOv: assert property (p_senseOv) else $error("sense overvoltage lost");

  property p_shortGnd;
    @(posedge core_clk) disable iff (!rst_n)
    senseShortGround |=> faultFlags[uef_pkg::FB_SHORT_GND];
  endproperty
  a_shortGnd: assert property (p_shortGnd) else $error("short to ground lost");

  property p_thermalSet;
    @(posedge core_clk) disable iff (!rst_n)
    thermalShutdown |=> faultFlags[uef_pkg::FB_THERMAL];
  endproperty
  a_thermalSet: assert property (p_thermalSet) else $error("thermal fault lost");

  property p_irqAdc;
    @(posedge core_clk) disable iff (!rst_n)
    (adcDone && notifMask_r[uef_pkg::NB_ADC_DONE] && !(regWrEn && selNotifMask)) |=>
      irqOut;
  endproperty
  a_irqAdc: assert property (p_irqAdc) else $error("adc flag gave no irq");
endmodule

// File: sim/uef_host_model.sv
`timescale 1ns/1ps
module uef_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end
  // released lines show the inverse, not a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge core_clk);
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask
endmodule

// File: sim/uef_port_flags_tb.sv
`timescale 1ns/1ps
module uef_port_flags_tb;
  typedef struct packed {
    logic [6:0] cond;
    logic       trip;
    logic [7:0] expv;
  } uef_row_t;
  logic       core_clk, rst_n, configDone, connStateChange, connAttachStatus;
  logic       connSourceState, legacyChargeAttach, adcDone, connDetectEnable;
  logic       limitTripMode, irqOut, regWrEn, regRdEn;
  logic [6:0] fv;
  logic [7:0] regAddr, regWrData, regRdData, rv;
  int         errors, check_count;
  // fault input order: preOv, limitUv, curLimit, ov, uv, short, thermal
  uef_row_t   rows [9] = '{
    '{7'h40, 1'h0, 8'h40}, '{7'h20, 1'h0, 8'h20}, '{7'h20, 1'h1, 8'h00},
    '{7'h10, 1'h1, 8'h10}, '{7'h10, 1'h0, 8'h00}, '{7'h08, 1'h0, 8'h08},
    '{7'h04, 1'h0, 8'h04}, '{7'h02, 1'h0, 8'h02}, '{7'h01, 1'h0, 8'h01}};

  uef_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  uef_port_flags dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .configDone(configDone), .connStateChange(connStateChange),
    .connAttachStatus(connAttachStatus), .connSourceState(connSourceState),
    .legacyChargeAttach(legacyChargeAttach), .adcDone(adcDone),
    .connDetectEnable(connDetectEnable), .busMonitorOv(fv[6]),
    .busLimitUndervoltRaw(fv[5]), .busCurrentLimitRaw(fv[4]), .senseOvervoltage(fv[3]),
    .senseUndervoltage(fv[2]), .senseShortGround(fv[1]), .thermalShutdown(fv[0]),
    .limitTripMode(limitTripMode), .irqOut(irqOut));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkBit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chkByte(n, e, rv);
  endtask
  task automatic pulseFault(input logic [6:0] c, input logic t);
    @(negedge core_clk);
    fv            = c;
    limitTripMode = t;
    @(negedge core_clk);
    fv            = 7'h00;
  endtask
  task automatic results;
    $display("counts errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    results();
  end
  initial begin
    {configDone, connStateChange, connAttachStatus, connSourceState} = 4'h0;
    {legacyChargeAttach, adcDone, limitTripMode} = 3'h0;
    connDetectEnable = 1'b1;
    fv = 7'h00;
    rst_n = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    rdChk("notif reset", 8'h0A, 8'h80);
    rdChk("fault reset", 8'h0B, 8'h00);
    rdChk("notif mask reset", 8'h07, 8'h00);
    rdChk("fault mask reset", 8'h08, 8'h00);
    rdChk("unmapped", 8'h3C, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      pulseFault(rows[i].cond, rows[i].trip);
      rdChk("fault row", 8'h0B, rows[i].expv);
      rdChk("fault row cleared", 8'h0B, 8'h00);
    end
    // pre-overvoltage only counts with detection on
    @(negedge core_clk);
    connDetectEnable = 1'b0;
    fv = 7'h40;
    @(negedge core_clk);
    connDetectEnable = 1'b1;
    fv = 7'h00;
    rdChk("pre-ov detect off", 8'h0B, 8'h00);
    $display("test fault table done");
    @(negedge core_clk);
    fv = 7'h08;
    rdChk("fault held", 8'h0B, 8'h08);
    rdChk("fault reread", 8'h0B, 8'h08);
    @(negedge core_clk);
    fv = 7'h00;
    rdChk("fault latched", 8'h0B, 8'h08);
    rdChk("fault resolved", 8'h0B, 8'h00);
    $display("test persistent fault done");
    host.wr(8'h07, 8'hFF);
    rdChk("notif mask", 8'h07, 8'hBF);
    host.wr(8'h08, 8'hFF);
    rdChk("fault mask", 8'h08, 8'h7F);
    host.wr(8'h07, 8'h01);
    host.wr(8'h08, 8'h01);
    pulseFault(7'h01, 1'b0);
    chkBit("irq fault", 1'b1, irqOut);
    host.wr(8'h08, 8'h00);
    chkBit("irq masked", 1'b0, irqOut);
    rdChk("fault thermal", 8'h0B, 8'h01);
    host.wr(8'h0B, 8'hFF);
    rdChk("fault read only", 8'h0B, 8'h00);
    $display("test masks done");
    @(negedge core_clk);
    adcDone = 1'b1;
    @(negedge core_clk);
    adcDone = 1'b0;
    chkBit("irq adc", 1'b1, irqOut);
    rdChk("adc set", 8'h0A, 8'h81);
    rdChk("adc cleared", 8'h0A, 8'h80);
    @(negedge core_clk);
    connStateChange = 1'b1;
    @(negedge core_clk);
    connStateChange = 1'b0;
    rdChk("state change", 8'h0A, 8'hA0);
    rdChk("state cleared", 8'h0A, 8'h80);
    @(negedge core_clk);
    {connSourceState, connAttachStatus} = 2'h3;
    rdChk("conn attach", 8'h0A, 8'h94);
    rdChk("conn held", 8'h0A, 8'h90);
    pulseFault(7'h40, 1'b0);
    rdChk("pre-ov attached", 8'h0B, 8'h00);
    @(negedge core_clk);
    {connSourceState, connAttachStatus} = 2'h0;
    rdChk("conn detach", 8'h0A, 8'h94);
    rdChk("conn idle", 8'h0A, 8'h80);
    @(negedge core_clk);
    legacyChargeAttach = 1'b1;
    rdChk("legacy attach", 8'h0A, 8'h8A);
    rdChk("legacy held", 8'h0A, 8'h88);
    @(negedge core_clk);
    legacyChargeAttach = 1'b0;
    rdChk("legacy detach", 8'h0A, 8'h8A);
    rdChk("legacy idle", 8'h0A, 8'h80);
    @(negedge core_clk);
    configDone = 1'b1;
    rdChk("configured", 8'h0A, 8'h00);
    $display("test notifications done");
    // auto-clear on: levels drop, events stay
    host.wr(8'h07, 8'h80);
    @(negedge core_clk);
    fv = 7'h01;
    rdChk("auto fault set", 8'h0B, 8'h01);
    @(negedge core_clk);
    fv = 7'h00;
    {connStateChange, legacyChargeAttach, adcDone} = 3'h7;
    @(negedge core_clk);
    {connStateChange, legacyChargeAttach, adcDone} = 3'h0;
    repeat (2) @(negedge core_clk);
    rdChk("auto fault gone", 8'h0B, 8'h00);
    rdChk("auto events kept", 8'h0A, 8'h23);
    $display("test auto clear done");
    // mid-run reset drops flags, masks and interrupt
    host.wr(8'h08, 8'h08);
    @(negedge core_clk);
    fv = 7'h08;
    @(negedge core_clk);
    chkBit("irq before reset", 1'b1, irqOut);
    rst_n = 1'b0;
    fv = 7'h00;
    @(negedge core_clk);
    chkBit("irq in reset", 1'b0, irqOut);
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    rdChk("fault after reset", 8'h0B, 8'h00);
    rdChk("mask after reset", 8'h07, 8'h00);
    $display("test mid-run reset done");
    results();
  end
endmodule
